// File: verilog/slot_switch_pkg.sv
// package for the slot switch connection map
// shared by the connection map block and its bench
package slot_switch_pkg;

  localparam int NUM_STREAMS    = 4;
  localparam int NUM_CHANNELS   = 32;
  localparam int BYTE_W         = 8;
  localparam int STREAM_W       = 2;
  localparam int CHAN_W         = 5;
  localparam int BIT_W          = 3;

  // high word fields
  localparam int HI_SRC_BIT     = 2;
  localparam int HI_OE_BIT      = 0;
  localparam logic [7:0] HI_MASK = 8'h05;

  // low word fields
  localparam int LO_STREAM_MSB  = 6;
  localparam int LO_STREAM_LSB  = 5;
  localparam int LO_CHAN_MSB    = 4;
  localparam int LO_CHAN_LSB    = 0;

  // control register fields
  localparam int CTL_PROC_BIT   = 6;
  localparam int CTL_MS_MSB     = 4;
  localparam int CTL_MS_LSB     = 3;
  localparam int CTL_STA_MSB    = 1;
  localparam int CTL_STA_LSB    = 0;
  localparam logic [1:0] MS_LOW  = 2'h2;
  localparam logic [1:0] MS_HIGH = 2'h3;

  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // processor write/read request
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [1:0]           mem_sel;
    logic [STREAM_W-1:0]  stream;
    logic [CHAN_W-1:0]    chan;
    logic [BYTE_W-1:0]    data;
  } cpu_req_s;

  // one output slot request: valid, channel, bit position
  typedef struct packed {
    logic                 valid;
    logic [CHAN_W-1:0]    chan;
    logic [BIT_W-1:0]     bit_idx;
  } slot_s;

endpackage : slot_switch_pkg

// File: verilog/slot_switch_connection_map.sv
// connection map of a four-stream time slot interchange switch
// assumes: receive memory read combinationally, one address per lane;
// slot timing and processor requests come from logic on I_REF_CLK
`timescale 1ns/10ps
module slot_switch_connection_map
  import slot_switch_pkg::*;
#(
  parameter int STREAMS  = slot_switch_pkg::NUM_STREAMS,
  parameter int CHANNELS = slot_switch_pkg::NUM_CHANNELS
) (
  input  wire logic                              I_REF_CLK,
  input  wire logic                              I_RESET_N,
  input  wire logic                              I_GLOBAL_OUTPUT_ENABLE_PIN,
  input  wire logic                              I_PROCESSOR_MODE_BIT,
  input  wire slot_switch_pkg::cpu_req_s         I_CPU_REQ,
  output logic [slot_switch_pkg::BYTE_W-1:0]     O_CPU_RDATA,
  input  wire slot_switch_pkg::slot_s            I_SLOT,
  output logic [STREAMS*(slot_switch_pkg::STREAM_W
                 + slot_switch_pkg::CHAN_W)-1:0] O_DM_CHAN,
  input  wire logic [STREAMS*slot_switch_pkg::BYTE_W-1:0] I_DM_DATA,
  output logic [STREAMS-1:0]                     O_TRANSMIT_STREAMS,
  output logic [STREAMS-1:0]                     O_TRANSMIT_STREAMS_OE_N
);
  import slot_switch_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [STREAMS*CHANNELS-1:0][BYTE_W-1:0] low_q;
    logic [STREAMS*CHANNELS-1:0][1:0]        high_q;
    logic [BYTE_W-1:0]                       rdata_q;
    logic [STREAMS-1:0]                      tx_q;
    logic [STREAMS-1:0]                      oe_n_q;
    logic                                    ode_m_q;
    logic                                    ode_q;
  } state_s;

  state_s st_q;
  state_s st_d;

  // --------------------------------------------------------------
  // local constants
  // --------------------------------------------------------------
  // receive memory address: stream field over channel field
  localparam int ADDR_W = STREAM_W + CHAN_W;
  // positions of the two stored high word bits
  localparam int HQ_SRC = 1;
  localparam int HQ_OE  = 0;

  // --------------------------------------------------------------
  // word index
  // --------------------------------------------------------------
  // flat word index from stream and channel
  function automatic logic [ADDR_W-1:0] word_idx(
    input logic [STREAM_W-1:0] s,
    input logic [CHAN_W-1:0]   c
  );
    word_idx = {s, c};
  endfunction : word_idx

  // --------------------------------------------------------------
  // high word packing
  // --------------------------------------------------------------
  // keep only source and enable bits of a written byte
  function automatic logic [1:0] high_pack(input logic [BYTE_W-1:0] d);
    logic [BYTE_W-1:0] m;
    m = d & HI_MASK;
    high_pack = {m[HI_SRC_BIT], m[HI_OE_BIT]};
  endfunction : high_pack

  // rebuild readable high byte from its two stored bits
  function automatic logic [7:0] high_byte(input logic [1:0] h);
    high_byte = ZERO_BYTE;
    high_byte[HI_SRC_BIT] = h[HQ_SRC];
    high_byte[HI_OE_BIT]  = h[HQ_OE];
  endfunction : high_byte

  // --------------------------------------------------------------
  // low word decoding
  // --------------------------------------------------------------
  // receive address from stream and channel fields
  function automatic logic [ADDR_W-1:0] lane_addr(
    input logic [BYTE_W-1:0] lo
  );
    lane_addr = {lo[LO_STREAM_MSB:LO_STREAM_LSB],
                 lo[LO_CHAN_MSB:LO_CHAN_LSB]};
  endfunction : lane_addr

  // --------------------------------------------------------------
  // lane byte and driver
  // --------------------------------------------------------------
  // byte sent on one lane for this slot
  function automatic logic [BYTE_W-1:0] lane_byte(
    input logic [1:0]        hi,
    input logic              proc,
    input logic [BYTE_W-1:0] lo,
    input logic [BYTE_W-1:0] dm
  );
    if (hi[HQ_SRC] || proc) begin
      lane_byte = lo;
    end else begin
      lane_byte = dm;
    end
  endfunction : lane_byte

  // active low driver enable of one lane
  function automatic logic lane_oe_n(
    input logic       global_output_enable_pin,
    input logic       proc,
    input logic [1:0] hi
  );
    if (!global_output_enable_pin) begin
      lane_oe_n = 1'b1;
    end else if (proc) begin
      lane_oe_n = 1'b0;
    end else begin
      lane_oe_n = ~hi[HQ_OE];
    end
  endfunction : lane_oe_n

  // serial bit of a byte, msb first
  function automatic logic serial_bit(
    input logic [BYTE_W-1:0] b,
    input logic [BIT_W-1:0]  i
  );
    serial_bit = b[BIT_W'(BYTE_W-1) - i];
  endfunction : serial_bit

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign O_CPU_RDATA             = st_q.rdata_q;
  assign O_TRANSMIT_STREAMS      = st_q.tx_q;
  assign O_TRANSMIT_STREAMS_OE_N = st_q.oe_n_q;

  // --------------------------------------------------------------
  // receive memory address per lane
  // --------------------------------------------------------------
  // each output lane fetches from its own low word's address
  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      O_DM_CHAN[s*ADDR_W +: ADDR_W] =
        lane_addr(st_q.low_q[word_idx(STREAM_W'(s), I_SLOT.chan)]);
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic [ADDR_W-1:0] idx;
    logic [ADDR_W-1:0] widx;
    logic [BYTE_W-1:0] lo;
    logic [1:0]        hi;
    logic [BYTE_W-1:0] out_byte;
    idx      = '0;
    widx     = '0;
    lo       = '0;
    hi       = '0;
    out_byte = '0;
    st_d     = st_q;

    // enable pin through two flops
    st_d.ode_m_q = I_GLOBAL_OUTPUT_ENABLE_PIN;
    st_d.ode_q   = st_q.ode_m_q;

    // processor access to selected stream's words
    widx = word_idx(I_CPU_REQ.stream, I_CPU_REQ.chan);
    if (I_CPU_REQ.wr) begin
      if (I_CPU_REQ.mem_sel == MS_LOW) begin
        st_d.low_q[widx] = I_CPU_REQ.data;
      end else if (I_CPU_REQ.mem_sel == MS_HIGH) begin
        st_d.high_q[widx] = high_pack(I_CPU_REQ.data);
      end
    end
    if (I_CPU_REQ.rd) begin
      if (I_CPU_REQ.mem_sel == MS_LOW) begin
        st_d.rdata_q = st_q.low_q[widx];
      end else if (I_CPU_REQ.mem_sel == MS_HIGH) begin
        st_d.rdata_q = high_byte(st_q.high_q[widx]);
      end else begin
        st_d.rdata_q = ZERO_BYTE;
      end
    end

    // every valid slot consults each stream's words
    if (I_SLOT.valid) begin
      for (int s = 0; s < STREAMS; s++) begin
        idx      = word_idx(STREAM_W'(s), I_SLOT.chan);
        lo       = st_q.low_q[idx];
        hi       = st_q.high_q[idx];
        out_byte = lane_byte(hi, I_PROCESSOR_MODE_BIT, lo,
                             I_DM_DATA[s*BYTE_W +: BYTE_W]);
        st_d.tx_q[s]   = serial_bit(out_byte, I_SLOT.bit_idx);
        st_d.oe_n_q[s] = lane_oe_n(st_q.ode_q, I_PROCESSOR_MODE_BIT,
                                   hi);
      end
    end else if (!st_q.ode_q) begin
      st_d.oe_n_q = '1;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      st_q        <= '0;
      st_q.oe_n_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : slot_switch_connection_map

// File: bench/slot_switch_asserts.sv
// assertions on the connection map top ports
// assumes: bound into slot_switch_connection_map
`timescale 1ns/10ps
module slot_switch_asserts
  import slot_switch_pkg::*;
#(parameter int STREAMS = 4) (
  input wire logic I_REF_CLK, I_RESET_N,
  input wire logic I_GLOBAL_OUTPUT_ENABLE_PIN, I_PROCESSOR_MODE_BIT,
  input wire slot_switch_pkg::cpu_req_s I_CPU_REQ,
  input wire logic [7:0] O_CPU_RDATA,
  input wire slot_switch_pkg::slot_s I_SLOT,
  input wire logic [STREAMS*7-1:0] O_DM_CHAN,
  input wire logic [STREAMS-1:0] O_TRANSMIT_STREAMS,
  input wire logic [STREAMS-1:0] O_TRANSMIT_STREAMS_OE_N
);
  wire cpu_req_s q = I_CPU_REQ;
  wire pin = I_GLOBAL_OUTPUT_ENABLE_PIN;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_lo_wr; q.wr && q.mem_sel == MS_LOW; endsequence
  sequence s_lo_rd; q.rd && q.mem_sel == MS_LOW && q.chan == $past(q.chan, 4)
    && q.stream == $past(q.stream, 4); endsequence
  a_high_spare_zero: assert property (
    q.rd && q.mem_sel == MS_HIGH |=> (O_CPU_RDATA & ~HI_MASK) == ZERO_BYTE)
    else $error("spare high bits read set");
  a_low_readback: assert property (
    s_lo_wr ##4 s_lo_rd |=> O_CPU_RDATA == $past(q.data, 5))
    else $error("low word readback wrong");
  a_sel_refused: assert property (
    q.rd && !q.mem_sel[1] |=> O_CPU_RDATA == ZERO_BYTE) else $error("bad sel");
  a_pin_low_off: assert property (
    !pin [*4] |=> &O_TRANSMIT_STREAMS_OE_N) else $error("driver on, pin low");
  a_proc_drive: assert property (
    pin [*4] ##0 (I_SLOT.valid && I_PROCESSOR_MODE_BIT)
    |=> O_TRANSMIT_STREAMS_OE_N == '0) else $error("proc mode not driving");
  a_oe_hold: assert property (
    pin [*4] ##0 !I_SLOT.valid |=> $stable(O_TRANSMIT_STREAMS_OE_N))
    else $error("enable moved without slot");
  a_tx_hold: assert property (
    !I_SLOT.valid |=> $stable(O_TRANSMIT_STREAMS)) else $error("tx moved");
  a_dm_chan: assert property (
    !q.wr |=> ($stable(I_SLOT.chan) |-> $stable(O_DM_CHAN)))
    else $error("memory address moved");
endmodule : slot_switch_asserts

// File: bench/rx_data_mem.sv
// receive data memory model beside the connection map
// assumes: read combinationally, one byte per lane from that lane's own address
`timescale 1ns/10ps
module rx_data_mem (
  input  wire logic [27:0] i_chan,
  output logic      [31:0] o_data
);
  always_comb begin
    for (int s = 0; s < 4; s++) o_data[8*s +: 8] = {1'b1, i_chan[7*s +: 7]};
  end
endmodule : rx_data_mem

// File: bench/slot_switch_connection_map_tb.sv
// bench for the slot switch connection map
// assumes: rx_data_mem supplies receive bytes
`timescale 1ns/10ps
module slot_switch_connection_map_tb;
  import slot_switch_pkg::*;
  logic clk = 0, rst_n = 0, pin = 0, proc = 0;
  cpu_req_s req = '0;
  slot_s slot = '0;
  logic [7:0] rdata;
  logic [27:0] dm_chan;
  logic [31:0] dm;
  logic [3:0] tx, oe_n;
  logic [7:0] hi [4] = '{8'h05, 8'h01, 8'h00, 8'h05};
  logic [7:0] lo [4] = '{8'hA5, 8'h40, 8'h81, 8'h3C};
  int fail_count = 0, num_checks = 0, cyc = 0;
  slot_switch_connection_map slot_switch_connection_map_i (.I_REF_CLK(clk),
    .I_RESET_N(rst_n), .I_GLOBAL_OUTPUT_ENABLE_PIN(pin),
    .I_PROCESSOR_MODE_BIT(proc), .I_CPU_REQ(req), .O_CPU_RDATA(rdata),
    .I_SLOT(slot), .O_DM_CHAN(dm_chan), .I_DM_DATA(dm),
    .O_TRANSMIT_STREAMS(tx), .O_TRANSMIT_STREAMS_OE_N(oe_n));
  rx_data_mem rx_data_mem_i (.i_chan(dm_chan), .o_data(dm));
  initial forever #12.5 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cpu(input logic w, input logic [1:0] ms, st,
                     input logic [7:0] d, exp);
    @(posedge clk) #2 req = '{w, !w, ms, st, 5'h03, d};
    @(posedge clk) #2 req = '0;
    if (!w) chk(rdata, exp);
  endtask : cpu
  task automatic run();
    logic [7:0] b;
    logic [3:0] et, eo;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) #2 slot = '{1'b1, 5'h03, 3'(i)};
      for (int s = 0; s < 4; s++) begin
        b = (hi[s][2] | proc) ? lo[s] : {1'b1, lo[s][6:0]};
        et[s] = b[7-i];
        eo[s] = !(pin && (proc || hi[s][0]));
      end
      @(posedge clk) #2 slot = '0;
      chk({4'h0, tx}, {4'h0, et});
      chk({4'h0, oe_n}, {4'h0, eo});
    end
  endtask : run
  initial begin
    repeat (12) @(posedge clk);
    #2 rst_n = 1;
    cpu(1'b0, MS_HIGH, 2'h1, 8'h00, 8'h00);
    for (int s = 0; s < 4; s++) begin
      cpu(1'b1, MS_HIGH, 2'(s), hi[s] | 8'hFA, 8'h00);
      cpu(1'b1, MS_LOW, 2'(s), lo[s], 8'h00);
      cpu(1'b0, MS_HIGH, 2'(s), 8'h00, hi[s]);
      cpu(1'b0, MS_LOW, 2'(s), 8'h00, lo[s]);
    end
    cpu(1'b1, 2'h1, 2'h0, 8'hFF, 8'h00);
    cpu(1'b0, 2'h1, 2'h0, 8'h00, 8'h00);
    run();
    pin = 1;
    repeat (4) @(posedge clk);
    run();
    proc = 1;
    run();
    pin = 0;
    repeat (4) @(posedge clk);
    run();
    end_sim();
  end
endmodule : slot_switch_connection_map_tb
bind slot_switch_connection_map slot_switch_asserts #(.STREAMS(STREAMS))
  slot_switch_asserts_i (.*);
